/* hdl/pzs_zone_manager.sv */
`timescale 1ns/1ps
`include "pzs_defs.svh"
module pzs_zone_manager (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic vout_regulated_in,
  input wire logic [1:0] power_save_select_in,
  input wire logic [7:0] phase_sense_positive_in,
  input wire logic [7:0] total_current_code_in,
  input wire logic [2:0] first_fixed_zone_strap_in,
  input wire logic [2:0] second_fixed_zone_strap_in,
  input wire logic [31:0] shed_threshold_strap_in,
  input wire logic [3:0] shed_threshold_float_in,
  input wire logic [7:0] loadline_address_strap_in,
  input wire logic [7:0] frequency_set_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] phase_enable_out,
  output logic [2:0] power_zone_out,
  output logic discontinuous_conduction_out,
  output logic [7:0] frequency_out,
  output logic [7:0] loadline_out,
  output logic [6:0] slave_address_out
);
  // ----------------------------------------------------------------
  // reset and input synchronisers
  // ----------------------------------------------------------------
  logic rst_s1_reg, rst_n;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end
  // pins pass two flops; the first stage is read by nothing else
  // cleared by the raw reset so both stages hold pin values by the time
  // the internal reset lets the one-cycle strap capture run
  logic [13:0] pin_s1_reg, pin_s2_reg;
  logic [7:0] sense_s1_reg, sense_s2_reg;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_reg <= 14'h0;
      pin_s2_reg <= 14'h0;
      sense_s1_reg <= 8'h00;
      sense_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= {enable_in, vout_regulated_in, power_save_select_in,
                     first_fixed_zone_strap_in, second_fixed_zone_strap_in,
                     shed_threshold_float_in};
      pin_s2_reg <= pin_s1_reg;
      sense_s1_reg <= phase_sense_positive_in;
      sense_s2_reg <= sense_s1_reg;
    end
  end
  logic en_s, regd_s;
  logic [1:0] ps_s;
  assign en_s = pin_s2_reg[13];
  assign regd_s = pin_s2_reg[12];
  assign ps_s = pin_s2_reg[11:10];
  // ----------------------------------------------------------------
  // power-up strap capture
  // ----------------------------------------------------------------
  pzs_pkg::pzs_state_t state_reg;
  logic [7:0] phase_en_reg, fixed_zone_reg, hyst_reg, delay_reg;
  logic [7:0] freq_reg, ll_reg, ctrl_reg, tc_reg;
  logic [7:0] thr_reg [4];
  logic [6:0] addr_reg;
  logic [1:0] ps_held_reg;
  logic low_again_reg;
  logic capture;
  assign capture = (state_reg == pzs_pkg::PZS_ST_DETECT);
  // straps are analog conversions in front of this block, so they are
  // taken as stable codes; one capture cycle after reset release
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pzs_pkg::PZS_ST_DETECT;
    end else begin
      case (state_reg)
        pzs_pkg::PZS_ST_DETECT: state_reg <= pzs_pkg::PZS_ST_SOFTSTART;
        pzs_pkg::PZS_ST_SOFTSTART:
          if (en_s && regd_s) state_reg <= pzs_pkg::PZS_ST_RUN;
        pzs_pkg::PZS_ST_RUN:
          if (!en_s) state_reg <= pzs_pkg::PZS_ST_SOFTSTART;
        default: state_reg <= pzs_pkg::PZS_ST_DETECT;
      endcase
    end
  end
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_en_reg <= 8'hFF;
    end else if (capture) begin
      phase_en_reg <= ~sense_s2_reg;
    end
  end
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) thr_reg[i] <= `PZS_THR_OFF;
      fixed_zone_reg <= 8'h00;
      hyst_reg <= `PZS_HYST_RESET;
      delay_reg <= `PZS_DELAY_RESET;
      freq_reg <= 8'h00;
      ll_reg <= 8'h00;
      addr_reg <= 7'h00;
      ctrl_reg <= 8'h00;
    end else if (capture) begin
      for (int i = 0; i < 4; i++) begin
        // strap at or above the 2 V code, or floating, disables it
        if (pin_s2_reg[i] ||
            shed_threshold_strap_in[i*8 +: 8] >= `PZS_STRAP_OFF_CODE)
          thr_reg[i] <= `PZS_THR_OFF;
        else
          thr_reg[i] <= shed_threshold_strap_in[i*8 +: 8];
      end
      fixed_zone_reg <= {2'h0, pin_s2_reg[4+:3], pin_s2_reg[7+:3]};
      freq_reg <= frequency_set_in;
      ll_reg <= {4'h0, loadline_address_strap_in[3:0]};
      addr_reg <= {3'h2, loadline_address_strap_in[7:4]};
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `PZS_REG_THR1: thr_reg[0] <= reg_wdata_in;
        `PZS_REG_THR2: thr_reg[1] <= reg_wdata_in;
        `PZS_REG_THR3: thr_reg[2] <= reg_wdata_in;
        `PZS_REG_THR4: thr_reg[3] <= reg_wdata_in;
        `PZS_REG_FIXED_ZONE: fixed_zone_reg <= reg_wdata_in;
        `PZS_REG_HYST: hyst_reg <= reg_wdata_in;
        `PZS_REG_SHED_DELAY: delay_reg <= reg_wdata_in;
        `PZS_REG_FREQ: freq_reg <= reg_wdata_in;
        `PZS_REG_LOADLINE: ll_reg <= reg_wdata_in;
        `PZS_REG_CTRL: ctrl_reg <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // power-save tracking and current sampling
  // ----------------------------------------------------------------
  logic [8:0] samp_cnt_reg;
  logic samp_tick;
  assign samp_tick = (samp_cnt_reg == 9'(`PZS_SAMPLE_CYC - 1));
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_reg <= 9'h000;
      tc_reg <= 8'h00;
    end else begin
      samp_cnt_reg <= samp_tick ? 9'h000 : samp_cnt_reg + 9'h001;
      if (samp_tick) tc_reg <= total_current_code_in;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ps_held_reg <= pzs_pkg::PZS_PS_HIGH;
      low_again_reg <= 1'b0;
    end else if (capture || !en_s) begin
      ps_held_reg <= ps_s;
      low_again_reg <= 1'b0;
    end else if (state_reg == pzs_pkg::PZS_ST_RUN) begin
      ps_held_reg <= ps_s;
      if (ps_s != pzs_pkg::PZS_PS_LOW) low_again_reg <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // target zone selection
  // ----------------------------------------------------------------
  logic [2:0] zone_reg, target, auto_zone;
  logic [3:0] thr_on;
  always_comb begin
    auto_zone = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      thr_on[i] = (thr_reg[i] != `PZS_THR_OFF);
      // hysteresis only applies when leaving toward a higher zone
      if (thr_on[i] && (tc_reg > thr_reg[i] ||
          (zone_reg <= 3'(i) && 9'(tc_reg) + 9'(hyst_reg) >= 9'(thr_reg[i]))))
        auto_zone = 3'(i);
    end
  end
  always_comb begin
    target = 3'h0;
    case (ps_held_reg)
      pzs_pkg::PZS_PS_HIGH: target = 3'h0;
      pzs_pkg::PZS_PS_MID:
        target = (state_reg == pzs_pkg::PZS_ST_RUN) ? auto_zone
               : 3'h0;
      pzs_pkg::PZS_PS_LOW: begin
        if (low_again_reg)
          target = ctrl_reg[`PZS_CTRL_SECONDARY] ? fixed_zone_reg[2:0]
                 : pin_s2_reg[9:7];
        else
          target = ctrl_reg[`PZS_CTRL_SECONDARY] ? fixed_zone_reg[5:3]
                 : pin_s2_reg[6:4];
      end
      default: target = 3'h0;
    endcase
  end
  // ----------------------------------------------------------------
  // stepwise transition
  // ----------------------------------------------------------------
  logic [2:0] next_step;
  logic [7:0] step_cnt_reg;
  logic [8:0] us_cnt_reg;
  always_comb begin
    next_step = zone_reg;
    // zone i belongs to threshold i; only zones strictly between present
    // and target are skipped, so a disabled target is still reached
    if (target > zone_reg) begin
      next_step = zone_reg + 3'h1;
      for (int i = 0; i < 4; i++)
        if (next_step == 3'(i) && 3'(i) < target && !thr_on[i])
          next_step = 3'(i + 1);
    end else if (target < zone_reg) begin
      next_step = zone_reg - 3'h1;
      for (int i = 3; i >= 1; i--)
        if (next_step == 3'(i) && 3'(i) > target && !thr_on[i])
          next_step = 3'(i - 1);
    end
  end
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      zone_reg <= 3'h0;
      step_cnt_reg <= 8'h00;
      us_cnt_reg <= 9'h000;
    end else if (target < zone_reg) begin
      zone_reg <= next_step;
      step_cnt_reg <= 8'h00;
      us_cnt_reg <= 9'h000;
    end else if (target > zone_reg) begin
      us_cnt_reg <= (us_cnt_reg == 9'(`PZS_STEP_CYC - 1)) ? 9'h000
                  : us_cnt_reg + 9'h001;
      if (us_cnt_reg == 9'(`PZS_STEP_CYC - 1)) begin
        if (step_cnt_reg + 8'h01 >= delay_reg) begin
          zone_reg <= next_step;
          step_cnt_reg <= 8'h00;
        end else begin
          step_cnt_reg <= step_cnt_reg + 8'h01;
        end
      end
    end else begin
      step_cnt_reg <= 8'h00;
      us_cnt_reg <= 9'h000;
    end
  end
  // ----------------------------------------------------------------
  // outputs and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 8'h00;
      phase_enable_out <= 8'h00;
      power_zone_out <= 3'h0;
      discontinuous_conduction_out <= 1'b0;
      frequency_out <= 8'h00;
      loadline_out <= 8'h00;
      slave_address_out <= 7'h00;
    end else begin
      phase_enable_out <= phase_en_reg;
      power_zone_out <= zone_reg;
      discontinuous_conduction_out <= (zone_reg == `PZS_DCM_ZONE);
      frequency_out <= freq_reg;
      loadline_out <= ll_reg;
      slave_address_out <= addr_reg;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `PZS_REG_PHASE_STATUS: reg_rdata_out <= phase_en_reg;
          `PZS_REG_THR1: reg_rdata_out <= thr_reg[0];
          `PZS_REG_THR2: reg_rdata_out <= thr_reg[1];
          `PZS_REG_THR3: reg_rdata_out <= thr_reg[2];
          `PZS_REG_THR4: reg_rdata_out <= thr_reg[3];
          `PZS_REG_FIXED_ZONE: reg_rdata_out <= fixed_zone_reg;
          `PZS_REG_HYST: reg_rdata_out <= hyst_reg;
          `PZS_REG_SHED_DELAY: reg_rdata_out <= delay_reg;
          `PZS_REG_FREQ: reg_rdata_out <= freq_reg;
          `PZS_REG_LOADLINE: reg_rdata_out <= ll_reg;
          `PZS_REG_CTRL: reg_rdata_out <= ctrl_reg;
          `PZS_REG_ZONE_STATUS: reg_rdata_out <= {5'h00, zone_reg};
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule : pzs_zone_manager

/* hdl/pzs_defs.svh */
`ifndef PZS_DEFS_SVH
`define PZS_DEFS_SVH
`define PZS_NUM_PHASES 8
`define PZS_REG_PHASE_STATUS 8'h30
`define PZS_REG_ZONE_STRAP 8'h31
`define PZS_REG_THR1 8'h32
`define PZS_REG_THR2 8'h33
`define PZS_REG_THR3 8'h34
`define PZS_REG_THR4 8'h35
`define PZS_REG_FIXED_ZONE 8'h36
`define PZS_REG_HYST 8'h37
`define PZS_REG_SHED_DELAY 8'h38
`define PZS_REG_FREQ 8'h39
`define PZS_REG_LOADLINE 8'h3A
`define PZS_REG_CTRL 8'h3B
`define PZS_REG_ZONE_STATUS 8'h3C
`define PZS_THR_OFF 8'hFF
`define PZS_STRAP_OFF_CODE 8'hCC
`define PZS_HYST_RESET 8'h10
`define PZS_DELAY_RESET 8'h14
`define PZS_SAMPLE_US 10
`define PZS_CLK_MHZ 50
`define PZS_SAMPLE_CYC (`PZS_SAMPLE_US * `PZS_CLK_MHZ)
`define PZS_STEP_US 10
`define PZS_STEP_CYC (`PZS_STEP_US * `PZS_CLK_MHZ)
`define PZS_DCM_ZONE 3'h4
`define PZS_CTRL_SECONDARY 0
`endif

/* hdl/pzs_pkg.sv */
package pzs_pkg;
  typedef enum logic [1:0] {
    PZS_PS_LOW = 2'b00,
    PZS_PS_MID = 2'b01,
    PZS_PS_HIGH = 2'b10
  } pzs_ps_t;
  typedef enum logic [1:0] {
    PZS_ST_DETECT = 2'b00,
    PZS_ST_SOFTSTART = 2'b01,
    PZS_ST_RUN = 2'b10
  } pzs_state_t;
endpackage : pzs_pkg

/* bench/pzs_host_model.sv */
`timescale 1ns/1ps
// ----
// host side of the three-level power-save pin
// ----
module pzs_host_model (
  input wire logic clock_in,
  input wire logic [1:0] level_req_in,
  output logic [1:0] power_save_select_out
);
  // level moves only just after an edge, never mid-cycle
  always_ff @(posedge clock_in) begin
    power_save_select_out <= level_req_in;
  end
endmodule : pzs_host_model

/* bench/pzs_zone_manager_asserts.sv */
`timescale 1ns/1ps
// ----
// zone manager port checker
// ----
module pzs_zone_manager_chk (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  input wire logic vout_regulated_in,
  input wire logic [1:0] power_save_select_in,
  input wire logic [7:0] loadline_address_strap_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] phase_enable_out,
  input wire logic [2:0] power_zone_out,
  input wire logic discontinuous_conduction_out,
  input wire logic [7:0] frequency_out,
  input wire logic [6:0] slave_address_out
);
  logic [4:0] up_cnt;
  logic [4:0] hi_cnt;
  logic [9:0] gap_cnt;
  logic [7:0] freq_wr;
  logic [2:0] zone_q;
  logic ready;
  logic run_hi;
  assign ready = up_cnt == 5'h1F;
  assign run_hi = enable_in && vout_regulated_in &&
                  power_save_select_in == 2'h2;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // strap capture lands a few cycles after release, so all but the two zone 4 conduction-mode checks and the power-save high check wait for ready
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_cnt <= 5'h00;
      hi_cnt <= 5'h00;
      gap_cnt <= 10'h000;
      freq_wr <= 8'h00;
      zone_q <= 3'h0;
    end else begin
      zone_q <= power_zone_out;
      if (!ready) begin
        up_cnt <= up_cnt + 5'h01;
      end
      if (!run_hi) begin
        hi_cnt <= 5'h00;
      end else if (hi_cnt != 5'h1F) begin
        hi_cnt <= hi_cnt + 5'h01;
      end
      if (power_zone_out != zone_q) begin
        gap_cnt <= 10'h000;
      end else if (gap_cnt != 10'h3FF) begin
        gap_cnt <= gap_cnt + 10'h001;
      end
      if (reg_wr_in && reg_addr_in == 8'h39) begin
        freq_wr <= reg_wdata_in;
      end
    end
  end
  a_dcm_in_zone4: assert property (
    (power_zone_out == 3'h4)[*2] |-> discontinuous_conduction_out)
    else $error("zone 4 without discontinuous mode");
  a_ccm_below_four: assert property (
    (power_zone_out != 3'h4)[*2] |-> !discontinuous_conduction_out)
    else $error("discontinuous mode outside zone 4");
  a_slave_addr_strap: assert property (
    ready |-> slave_address_out == {3'b010, loadline_address_strap_in[7:4]})
    else $error("slave address does not follow strap");
  a_phase_map_read: assert property (
    ready && reg_rd_in && reg_addr_in == 8'h30 |=> ##[0:1]
    reg_rdata_out == phase_enable_out)
    else $error("phase status read differs from phase map");
  a_phase_map_fixed: assert property (
    ready |=> $stable(phase_enable_out))
    else $error("phase map changed after power-up");
  a_freq_applied: assert property (
    ready && reg_wr_in && reg_addr_in == 8'h39 |-> ##[1:3]
    frequency_out == freq_wr)
    else $error("written frequency not applied");
  a_high_all_on: assert property (
    hi_cnt == 5'h1F |-> power_zone_out == 3'h0)
    else $error("power-save high but not zone 0");
  a_up_step_gap: assert property (
    ready && power_zone_out > zone_q |-> gap_cnt >= 10'd490)
    else $error("zone went up without the shed delay");
  c_zone_four: cover property (power_zone_out == 3'h4);
  c_zone_up: cover property (ready && power_zone_out > zone_q);
  c_status_read: cover property (reg_rd_in && reg_addr_in == 8'h30);
endmodule : pzs_zone_manager_chk
bind pzs_zone_manager pzs_zone_manager_chk u_chk (
  .clock_in(clock_in), .nrst_in(nrst_in), .enable_in(enable_in),
  .vout_regulated_in(vout_regulated_in),
  .power_save_select_in(power_save_select_in),
  .loadline_address_strap_in(loadline_address_strap_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .phase_enable_out(phase_enable_out), .power_zone_out(power_zone_out),
  .discontinuous_conduction_out(discontinuous_conduction_out),
  .frequency_out(frequency_out), .slave_address_out(slave_address_out));

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clock_in;
  logic nrst_in = 1'b0;
  logic en = 1'b1;
  logic vreg = 1'b0;
  logic [1:0] ps_req = 2'h0;
  logic [1:0] ps;
  logic [7:0] sense = 8'hC0;
  logic [7:0] cur = 8'h90;
  logic [2:0] fz1 = 3'h3;
  logic [2:0] fz2 = 3'h1;
  logic [31:0] thr = 32'h20406080;
  logic [3:0] flt = 4'h0;
  logic [7:0] lls = 8'h5A;
  logic [7:0] fset = 8'h2D;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] phases;
  logic [2:0] zone;
  logic discontinuous_conduction;
  logic [7:0] freq;
  logic [7:0] ll;
  logic [6:0] saddr;
  logic [7:0] ra [10] = '{8'h30, 8'h32, 8'h33, 8'h35, 8'h36, 8'h37, 8'h38,
    8'h39, 8'h3D, 8'h00};
  logic [7:0] re [10] = '{8'h3F, 8'h80, 8'h60, 8'h20, 8'h0B, 8'h10, 8'h14,
    8'h2D, 8'h00, 8'h00};
  int n_fail = 0;
  int n_checks = 0;
  pzs_host_model u_pzs_host_model (.clock_in(clock_in),
    .level_req_in(ps_req), .power_save_select_out(ps));
  pzs_zone_manager u_pzs_zone_manager (.clock_in(clock_in),
    .nrst_in(nrst_in), .enable_in(en), .vout_regulated_in(vreg),
    .power_save_select_in(ps), .phase_sense_positive_in(sense),
    .total_current_code_in(cur), .first_fixed_zone_strap_in(fz1),
    .second_fixed_zone_strap_in(fz2), .shed_threshold_strap_in(thr),
    .shed_threshold_float_in(flt), .loadline_address_strap_in(lls),
    .frequency_set_in(fset), .reg_wr_in(wr_en), .reg_rd_in(rd_en),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .phase_enable_out(phases), .power_zone_out(zone),
    .discontinuous_conduction_out(discontinuous_conduction), .frequency_out(freq),
    .loadline_out(ll), .slave_address_out(saddr));
  // ----
  // shared tasks
  // ----
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr_en <= 1'b0;
    step(1);
  endtask : wr
  // one spare edge so either output timing is covered; data holds anyway
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd_en <= 1'b0;
    step(1);
    d = rdata;
  endtask : rd
  task automatic wait_zone(input logic [2:0] z, input int lim,
    output int n, output logic [7:0] m);
    n = 0;
    m = 8'h00;
    m[zone] = 1'b1;
    while (zone !== z && n < lim) begin
      step(1);
      m[zone] = 1'b1;
      n++;
    end
    if (zone !== z) begin
      n_fail++;
      $display("unexpected at %0t: zone wait ran out", $time);
      close_out();
    end
  endtask : wait_zone
  // ----
  // scenarios
  // ----
  task automatic t_straps;
    logic [7:0] d;
    wr(8'h30, 8'h00);
    wr(8'h3D, 8'h55);
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], d);
      chk(d, re[i]);
    end
    chk(phases, 8'h3F);
    chk({1'b0, saddr}, 8'h25);
    chk(ll, 8'h0A);
  endtask : t_straps
  task automatic t_settle;
    logic [2:0] z0;
    int n;
    logic [7:0] m;
    z0 = zone;
    ps_req <= 2'h1;
    step(600);
    chk(zone, z0);
    ps_req <= 2'h0;
    wr(8'h38, 8'h01);
    wr(8'h39, 8'h33);
    wr(8'h3A, 8'h07);
    chk(freq, 8'h33);
    chk(ll, 8'h07);
    vreg <= 1'b1;
    wait_zone(3'h1, 12000, n, m);
    chk(discontinuous_conduction, 1'b0);
  endtask : t_settle
  task automatic t_fixed;
    int n;
    logic [7:0] m;
    wr(8'h3B, 8'h01);
    wr(8'h36, 8'h14);
    wait_zone(3'h2, 2000, n, m);
    chk(8'(n >= 490), 8'h01);
    ps_req <= 2'h2;
    wait_zone(3'h0, 40, n, m);
    chk(8'(n <= 12), 8'h01);
    ps_req <= 2'h0;
    wait_zone(3'h4, 3000, n, m);
    chk(m, 8'h1F);
    chk(8'(n >= 1960), 8'h01);
    chk(discontinuous_conduction, 1'b1);
  endtask : t_fixed
  task automatic t_shed;
    int n;
    logic [7:0] m;
    ps_req <= 2'h1;
    wait_zone(3'h0, 1200, n, m);
    cur <= 8'h70;
    step(1500);
    chk(zone, 3'h0);
    cur <= 8'h6F;
    wait_zone(3'h1, 1600, n, m);
    wr(8'h34, 8'hFF);
    cur <= 8'h05;
    wait_zone(3'h4, 3000, n, m);
    chk(8'(m[2]), 8'h00);
    chk(8'(m[3]), 8'h01);
  endtask : t_shed
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'b1;
    step(10);
    t_straps();
    t_settle();
    t_fixed();
    t_shed();
    close_out();
  end
endmodule : tb_top
